/* logic/suw_uart.sv */
// Multi-channel serial channel with parity, nine-bit wake-up and shift mode
`timescale 1ns/1ps

module suw_uart #(
   parameter int N_CH     = 3,    // Number of channels
   parameter int BAUD_DIV = 54    // System clocks per oversample tick
) (
   // Clock and reset
   input  wire logic                            clk,
   input  wire logic                            rst,
   // Configuration and software strobes
   input  wire suw_pkg::suw_cfg_s [N_CH-1:0]    cfg,
   input  wire logic [N_CH-1:0]                 wakeup_set,
   input  wire logic [N_CH-1:0]                 error_clear,
   input  wire logic [N_CH-1:0]                 rx_read,
   // Transmit data handshake
   input  wire logic [N_CH-1:0]                 tx_valid,
   input  wire logic [N_CH-1:0][7:0]            tx_data,
   output logic [N_CH-1:0]                      tx_ready,
   // Receive status and events
   output suw_pkg::suw_stat_s [N_CH-1:0]        stat,
   output logic [N_CH-1:0]                      wakeup_filter_enable,
   output logic [N_CH-1:0]                      receive_irq,
   output logic [N_CH-1:0]                      transmit_irq,
   // Serial pins
   input  wire logic [N_CH-1:0]                 serial_in_pin,
   output logic [N_CH-1:0]                      serial_out_o,
   output logic [N_CH-1:0]                      serial_out_oe,
   input  wire logic [N_CH-1:0]                 shift_clock_i,
   output logic [N_CH-1:0]                      shift_clock_o,
   output logic [N_CH-1:0]                      shift_clock_oe
);

   // Oversample tick divider, shared by all channels
   logic [15:0] div_reg;            // Divider count
   logic [15:0] div_next;           // Next divider count
   logic        tick16;             // One pulse per sixteenth of a bit

   // Divider next value
   always_comb begin
      tick16   = (div_reg == 16'(BAUD_DIV - 1));
      div_next = tick16 ? '0 : div_reg + 16'h0001;
   end

   // Divider register
   always_ff @(posedge clk) begin
      if (rst) begin
         div_reg <= '0;
      end else begin
         div_reg <= div_next;
      end
   end

   for (genvar g = 0; g < N_CH; g++) begin : g_ch
      suw_pkg::suw_cfg_s c;        // This channel's configuration
      logic       is_shift;        // Shift mode selected
      logic       is9;             // Nine-bit mode selected
      logic       has_ext;         // Frame has ninth or parity bit
      logic       early;           // Receive event before the stop bit
      logic [3:0] nbits;           // Data bits per frame
      logic [7:0] td;              // Transmit data, masked to width
      logic       ext_bit;         // Ninth or parity bit to send
      logic [10:0] fr;             // Whole transmit frame, LSB first

      // Decoded mode
      assign c        = cfg[g];
      assign is_shift = (c.frame_mode_select == suw_pkg::MODE_SHIFT);
      assign is9      = (c.frame_mode_select == suw_pkg::MODE_9BIT);
      assign has_ext  = is9 || c.parity_add_enable;
      assign nbits    = (c.frame_mode_select == suw_pkg::MODE_7BIT) ?
                        suw_pkg::BITS7 : suw_pkg::BITS8;
      assign early    = is9 || ((c.frame_mode_select == suw_pkg::MODE_8BIT)
                        && c.parity_add_enable);

      // Frame builder for the asynchronous transmitter
      always_comb begin
         td      = tx_data[g];
         if (nbits == suw_pkg::BITS7) begin
            td[7] = 1'b0;
         end
         ext_bit = is9 ? c.tx_ninth_bit : (^td ^ ~c.parity_even);
         fr      = '1;
         fr[0]   = suw_pkg::START_LVL;
         fr[8:1] = td;
         fr[4'(nbits + 4'h1)] = has_ext ? ext_bit : suw_pkg::STOP_LVL;
      end

      // Transmit and shift engine state
      suw_pkg::suw_tx_e tx_st_reg, tx_st_next;
      logic [10:0] tx_sh_reg, tx_sh_next;      // Outgoing bits, LSB on the line
      logic [3:0]  tx_cnt_reg, tx_cnt_next;    // Bits left, or shift bits done
      logic [3:0]  tx_tick_reg, tx_tick_next;  // Tick within bit or half clock
      logic        sclk_reg, sclk_next;        // Internal shift clock level
      logic [7:0]  srx_reg, srx_next;          // Shift-mode receive register
      logic        has_reg, has_next;          // Shift cycle carries send data
      logic        txi_reg, txi_next;          // Transmit event pulse
      logic        sclk_q_reg;                 // Previous external clock level
      logic        ld_sh;                      // Shift byte goes to buffer
      logic        int_edge;                   // Internal clock toggles now
      logic        act;                        // Sampling edge of shift clock
      logic        drv;                        // Driving edge of shift clock

      // Shift clock edges; the pin is taken as synchronous to clk
      always_comb begin
         int_edge = tick16 && (tx_tick_reg == suw_pkg::TICK_MID);
         if (c.shift_clk_external) begin
            act = c.shift_clk_falling ? (sclk_q_reg & ~shift_clock_i[g])
                                      : (~sclk_q_reg & shift_clock_i[g]);
            drv = c.shift_clk_falling ? (~sclk_q_reg & shift_clock_i[g])
                                      : (sclk_q_reg & ~shift_clock_i[g]);
         end else begin
            act = int_edge && !sclk_reg;
            drv = int_edge && sclk_reg;
         end
      end

      // Transmit next state
      always_comb begin
         tx_st_next   = tx_st_reg;
         tx_sh_next   = tx_sh_reg;
         tx_cnt_next  = tx_cnt_reg;
         tx_tick_next = tx_tick_reg;
         sclk_next    = sclk_reg;
         srx_next     = srx_reg;
         has_next     = has_reg;
         txi_next     = 1'b0;
         ld_sh        = 1'b0;
         case (tx_st_reg)
            suw_pkg::TX_IDLE: begin
               tx_tick_next = '0;
               sclk_next    = 1'b1;
               // Asynchronous frame
               if (!is_shift && tx_valid[g]) begin
                  tx_st_next  = suw_pkg::TX_UART;
                  tx_sh_next  = fr;
                  tx_cnt_next = nbits + {3'h0, has_ext} + 4'h2;
               // Shift cycle to send, or to fetch a byte when buffer is free
               end else if (is_shift && (tx_valid[g] ||
                            (c.receive_enable && !stat[g].full))) begin
                  tx_st_next  = suw_pkg::TX_SHIFT;
                  tx_sh_next  = {3'h7, tx_valid[g] ? tx_data[g] : 8'hff};
                  tx_cnt_next = '0;
                  has_next    = tx_valid[g];
               end
            end
            suw_pkg::TX_UART: begin
               if (tick16) begin
                  tx_tick_next = tx_tick_reg + 4'h1;
                  // End of a bit: shift in idle level
                  if (tx_tick_reg == suw_pkg::TICK_LAST) begin
                     tx_sh_next  = {suw_pkg::STOP_LVL, tx_sh_reg[10:1]};
                     tx_cnt_next = tx_cnt_reg - 4'h1;
                     if (tx_cnt_reg == 4'h2) begin
                        txi_next = 1'b1;
                     end
                     if (tx_cnt_reg == 4'h1) begin
                        tx_st_next = suw_pkg::TX_IDLE;
                     end
                  end
               end
            end
            suw_pkg::TX_SHIFT: begin
               // Internal clock: half period of eight ticks
               if (!c.shift_clk_external && tick16) begin
                  tx_tick_next = tx_tick_reg + 4'h1;
                  if (int_edge) begin
                     tx_tick_next = '0;
                     sclk_next    = ~sclk_reg;
                  end
               end
               // Data moves on the driving edge after the first bit
               if (drv && (tx_cnt_reg != 4'h0)) begin
                  tx_sh_next = {suw_pkg::STOP_LVL, tx_sh_reg[10:1]};
               end
               // Sampling edge; the last one ends the cycle
               if (act) begin
                  srx_next    = {serial_in_pin[g], srx_reg[7:1]};
                  tx_cnt_next = tx_cnt_reg + 4'h1;
                  if (tx_cnt_reg == suw_pkg::SHIFT_LAST) begin
                     tx_st_next = suw_pkg::TX_IDLE;
                     tx_sh_next = '1;
                     txi_next   = has_reg;
                     ld_sh      = c.receive_enable;
                  end
               end
            end
            default: begin
               tx_st_next = suw_pkg::TX_IDLE;
            end
         endcase
      end

      // Transmit registers
      always_ff @(posedge clk) begin
         if (rst) begin
            tx_st_reg   <= suw_pkg::TX_IDLE;
            tx_sh_reg   <= '1;
            tx_cnt_reg  <= '0;
            tx_tick_reg <= '0;
            sclk_reg    <= 1'b1;
            srx_reg     <= '0;
            has_reg     <= 1'b0;
            txi_reg     <= 1'b0;
            sclk_q_reg  <= 1'b1;
         end else begin
            tx_st_reg   <= tx_st_next;
            tx_sh_reg   <= tx_sh_next;
            tx_cnt_reg  <= tx_cnt_next;
            tx_tick_reg <= tx_tick_next;
            sclk_reg    <= sclk_next;
            srx_reg     <= srx_next;
            has_reg     <= has_next;
            txi_reg     <= txi_next;
            sclk_q_reg  <= shift_clock_i[g];
         end
      end

      // Asynchronous receiver state
      suw_pkg::suw_rx_e rx_st_reg, rx_st_next;
      logic [3:0] rx_tick_reg, rx_tick_next;   // Tick within bit
      logic [3:0] rx_idx_reg, rx_idx_next;     // Bit number after start
      logic [7:0] rsh_reg, rsh_next;           // Collected data bits
      logic       ld_u;                        // Frame goes to buffer
      logic       ld_ninth;                    // Ninth bit of that frame
      logic       pe_s;                        // Parity mismatch strobe
      logic       fe_s;                        // Stop bit low strobe

      // Receiver next state; every sample is taken at a bit's middle
      always_comb begin
         rx_st_next   = rx_st_reg;
         rx_tick_next = rx_tick_reg;
         rx_idx_next  = rx_idx_reg;
         rsh_next     = rsh_reg;
         ld_u         = 1'b0;
         ld_ninth     = 1'b0;
         pe_s         = 1'b0;
         fe_s         = 1'b0;
         case (rx_st_reg)
            suw_pkg::RX_IDLE: begin
               rx_tick_next = '0;
               if (c.receive_enable && !is_shift &&
                   (serial_in_pin[g] == suw_pkg::START_LVL)) begin
                  rx_st_next = suw_pkg::RX_START;
               end
            end
            suw_pkg::RX_START: begin
               if (tick16) begin
                  rx_tick_next = rx_tick_reg + 4'h1;
                  // Mid start bit: a high line was only a glitch
                  if (rx_tick_reg == suw_pkg::TICK_MID) begin
                     rx_tick_next = '0;
                     rx_idx_next  = 4'h1;
                     rsh_next     = '0;
                     rx_st_next   = (serial_in_pin[g] == suw_pkg::START_LVL) ?
                                    suw_pkg::RX_DATA : suw_pkg::RX_IDLE;
                  end
               end
            end
            suw_pkg::RX_DATA: begin
               if (tick16) begin
                  rx_tick_next = rx_tick_reg + 4'h1;
                  if (rx_tick_reg == suw_pkg::TICK_LAST) begin
                     rx_idx_next = rx_idx_reg + 4'h1;
                     if (rx_idx_reg <= nbits) begin
                        rsh_next[3'(rx_idx_reg - 4'h1)] = serial_in_pin[g];
                     end else if (has_ext && (rx_idx_reg == nbits + 4'h1)) begin
                        ld_ninth = is9 & serial_in_pin[g];
                        pe_s     = !is9 && (serial_in_pin[g] !=
                                   (^rsh_reg ^ ~c.parity_even));
                        ld_u     = early;
                     end else begin
                        fe_s       = (serial_in_pin[g] != suw_pkg::STOP_LVL);
                        ld_u       = !early;
                        rx_st_next = suw_pkg::RX_IDLE;
                     end
                  end
               end
            end
            default: begin
               rx_st_next = suw_pkg::RX_IDLE;
            end
         endcase
      end

      // Receiver registers
      always_ff @(posedge clk) begin
         if (rst) begin
            rx_st_reg   <= suw_pkg::RX_IDLE;
            rx_tick_reg <= '0;
            rx_idx_reg  <= '0;
            rsh_reg     <= '0;
         end else begin
            rx_st_reg   <= rx_st_next;
            rx_tick_reg <= rx_tick_next;
            rx_idx_reg  <= rx_idx_next;
            rsh_reg     <= rsh_next;
         end
      end

      // Receive buffer, flags and wake-up filter
      suw_pkg::suw_stat_s st_reg, st_next;
      logic wake_reg, wake_next;               // Wake-up filter enable
      logic rxi_reg, rxi_next;                 // Receive event pulse
      logic supp;                              // Frame dropped by the filter

      // Buffer next state; each flag set is applied after its clear so it wins, but a code match clears the filter after wakeup_set
      always_comb begin
         st_next   = st_reg;
         wake_next = wake_reg;
         rxi_next  = 1'b0;
         if (rx_read[g]) begin
            st_next.full = 1'b0;
         end
         if (error_clear[g]) begin
            st_next.overrun_flag       = 1'b0;
            st_next.parity_fault_flag  = 1'b0;
            st_next.framing_fault_flag = 1'b0;
         end
         if (wakeup_set[g]) begin
            wake_next = 1'b1;
         end
         // Payload frames pass only once this slave was selected
         supp = is9 && wake_reg && !ld_ninth;
         if ((ld_u && !supp) || ld_sh) begin
            rxi_next = 1'b1;
            if (st_next.full) begin
               st_next.overrun_flag = 1'b1;
            end else begin
               st_next.data         = ld_sh ? {serial_in_pin[g], srx_reg[7:1]} : rsh_reg;
               st_next.rx_ninth_bit = ld_ninth;
               st_next.full         = 1'b1;
            end
            if (ld_u && is9 && wake_reg && (rsh_reg == c.own_select_code)) begin
               wake_next = 1'b0;
            end
         end
         if (pe_s) begin
            st_next.parity_fault_flag = 1'b1;
         end
         if (fe_s) begin
            st_next.framing_fault_flag = 1'b1;
         end
      end

      // Buffer registers
      always_ff @(posedge clk) begin
         if (rst) begin
            st_reg   <= '0;
            wake_reg <= 1'b0;
            rxi_reg  <= 1'b0;
         end else begin
            st_reg   <= st_next;
            wake_reg <= wake_next;
            rxi_reg  <= rxi_next;
         end
      end

      // Outputs; open drain only ever pulls low
      assign stat[g]                 = st_reg;
      assign wakeup_filter_enable[g] = wake_reg;
      assign receive_irq[g]          = rxi_reg;
      assign transmit_irq[g]         = txi_reg;
      assign tx_ready[g]             = (tx_st_reg == suw_pkg::TX_IDLE);
      assign serial_out_o[g]  = c.open_drain_select ? 1'b0 : tx_sh_reg[0];
      assign serial_out_oe[g] = c.open_drain_select ? ~tx_sh_reg[0] : 1'b1;
      assign shift_clock_o[g]  = sclk_reg;
      assign shift_clock_oe[g] = is_shift && !c.shift_clk_external;
   end

endmodule : suw_uart

/* pkg/suw_pkg.sv */
// Shared constants, types and state encodings of the multi-channel serial block
package suw_pkg;

   // Frame mode field encodings
   localparam logic [1:0] MODE_SHIFT = 2'h0;   // Synchronous shift mode
   localparam logic [1:0] MODE_7BIT  = 2'h1;   // Seven data bits
   localparam logic [1:0] MODE_8BIT  = 2'h2;   // Eight data bits
   localparam logic [1:0] MODE_9BIT  = 2'h3;   // Eight data bits plus ninth bit

   // Line levels
   localparam logic START_LVL = 1'b0;          // Start bit level
   localparam logic STOP_LVL  = 1'b1;          // Stop bit and idle level

   // Bit timing in oversample ticks, and data bit counts and indices
   localparam logic [3:0] TICK_LAST  = 4'hf;   // Last tick of a 16-tick bit
   localparam logic [3:0] TICK_MID   = 4'h7;   // Half a bit, also half shift clock
   localparam logic [3:0] BITS7      = 4'h7;   // Data bits, seven-bit mode
   localparam logic [3:0] BITS8      = 4'h8;   // Data bits, other modes
   localparam logic [3:0] SHIFT_LAST = 4'h7;   // Index of the last shift-mode bit

   // Transmit and shift engine states
   typedef enum logic [1:0] {
      TX_IDLE  = 2'b00,
      TX_UART  = 2'b01,
      TX_SHIFT = 2'b10
   } suw_tx_e;

   // Asynchronous receive states
   typedef enum logic [1:0] {
      RX_IDLE  = 2'b00,
      RX_START = 2'b01,
      RX_DATA  = 2'b10
   } suw_rx_e;

   // Per-channel configuration bits
   typedef struct packed {
      logic [1:0] frame_mode_select;   // Frame mode field
      logic       parity_add_enable;   // Add and check parity
      logic       parity_even;         // 1 even parity, 0 odd
      logic       tx_ninth_bit;        // Ninth bit sent in nine-bit mode
      logic       receive_enable;      // Receiver may accept data
      logic       shift_clk_external;  // Shift clock comes from the pin
      logic       shift_clk_falling;   // External clock active on falling edge
      logic       open_drain_select;   // Serial output is open drain
      logic [7:0] own_select_code;     // Address this channel answers to
   } suw_cfg_s;

   // Per-channel receive status
   typedef struct packed {
      logic [7:0] data;                // Received data buffer
      logic       rx_ninth_bit;        // Ninth bit of the buffered frame
      logic       overrun_flag;        // Frame lost, buffer still unread
      logic       parity_fault_flag;   // Parity mismatch seen
      logic       framing_fault_flag;  // Stop bit sampled low
      logic       full;                // Buffer holds unread data
   } suw_stat_s;

endpackage : suw_pkg

/* sim/suw_uart_chk.sv */
// Concurrent checks on channel 0 of the serial block
`timescale 1ns/1ps
module suw_uart_chk #(
   parameter int N_CH = 3                                 // Number of channels
) (
   // Clock and reset
   input  wire logic                          clk,
   input  wire logic                          rst,
   // Watched ports
   input  wire suw_pkg::suw_cfg_s [N_CH-1:0]  cfg,
   input  wire logic [N_CH-1:0]               tx_ready,
   input  wire suw_pkg::suw_stat_s [N_CH-1:0] stat,
   input  wire logic [N_CH-1:0]               wakeup_filter_enable,
   input  wire logic [N_CH-1:0]               receive_irq,
   input  wire logic [N_CH-1:0]               transmit_irq,
   input  wire logic [N_CH-1:0]               serial_out_o,
   input  wire logic [N_CH-1:0]               serial_out_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Wire level, pulled up when the driver lets go
   wire line = !serial_out_oe[0] || serial_out_o[0];
   // Asynchronous frame modes only
   wire uart = cfg[0].frame_mode_select != suw_pkg::MODE_SHIFT;
   chk_tx_irq_stop: assert property (transmit_irq[0] && uart |-> line [*8])
      else $error("transmit event not at stop bit");
   chk_start_low: assert property ($fell(tx_ready[0]) && uart |-> !line)
      else $error("frame did not open with a low start bit");
   chk_open_drain: assert property (cfg[0].open_drain_select |-> !serial_out_o[0])
      else $error("open drain output driven high");
   chk_ready_busy: assert property (transmit_irq[0] && uart |-> !tx_ready[0] [*8])
      else $error("sender idle during stop bit");
   chk_wake_drop: assert property (receive_irq[0] && $past(wakeup_filter_enable[0])
      && cfg[0].frame_mode_select == suw_pkg::MODE_9BIT |-> stat[0].rx_ninth_bit)
      else $error("filtered frame raised receive event");
   chk_wake_clear: assert property ($fell(wakeup_filter_enable[0]) |->
      receive_irq[0] && stat[0].data == cfg[0].own_select_code)
      else $error("filter cleared without matching code");
   chk_seven_top: assert property (receive_irq[0]
      && cfg[0].frame_mode_select == suw_pkg::MODE_7BIT |-> !stat[0].data[7])
      else $error("seven-bit frame stored a top bit");
   chk_irq_full: assert property (receive_irq[0] |-> stat[0].full)
      else $error("receive event with empty buffer");
   chk_no_parity9: assert property ($rose(stat[0].parity_fault_flag) |->
      cfg[0].frame_mode_select != suw_pkg::MODE_9BIT)
      else $error("parity checked in nine-bit mode");
endmodule : suw_uart_chk

bind suw_uart suw_uart_chk #(.N_CH(N_CH)) suw_uart_chk_inst (
   .clk(clk), .rst(rst), .cfg(cfg), .tx_ready(tx_ready), .stat(stat),
   .wakeup_filter_enable(wakeup_filter_enable), .receive_irq(receive_irq),
   .transmit_irq(transmit_irq), .serial_out_o(serial_out_o), .serial_out_oe(serial_out_oe));

/* sim/suw_peer.sv */
// Far-side controller driving the receive line of channel 0
`timescale 1ns/1ps
module suw_peer (
   // Clock
   input  wire logic clk,
   // Line toward the block
   output logic      line
);
   initial line = 1'h1;                       // Idle high before any frame
   // Sends n line bits LSB first; last bit cut short so a low stop bit ends
   task automatic drive(input logic [11:0] f, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         line <= f[i];
         repeat ((i == n - 1) ? 11 : 15) @(posedge clk);
      end
      @(posedge clk);
      line <= 1'h1;                           // Back to idle
   endtask : drive
endmodule : suw_peer

/* sim/test_suw_uart.sv */
// Self-checking bench of the serial block, channel 0
`timescale 1ns/1ps
module test_suw_uart;
   logic                     clk = 1'h0;  // System clock
   logic                     rst = 1'h1;  // Synchronous reset
   suw_pkg::suw_cfg_s [2:0]  cfg = '0;    // Settings
   logic [2:0]               wset = '0;   // Filter set
   logic [2:0]               eclr = '0;   // Flag clear
   logic [2:0]               rrd = '0;    // Buffer read
   logic [2:0]               tval = '0;   // Send request
   logic [2:0][7:0]          tdat = '0;   // Send data
   logic [2:0]               trdy, wake, rirq, tirq, so, soe, sclk, scoe;
   logic                     xclk = 1'h1; // External shift clock, idles high
   suw_pkg::suw_stat_s [2:0] stat;        // Receive status
   logic                     pin;         // Peer line
   wire                      line = !soe[0] || so[0];  // Pull-up
   int                       num_errors = 0;
   int                       compares = 0;
   int                       rx_cnt = 0;  // Receive events
   int                       tx_cnt = 0;  // Transmit events
   initial begin
      forever #5 clk = ~clk;
   end
   // Event counters, never cleared
   always @(posedge clk) begin
      rx_cnt <= rx_cnt + rirq[0];
      tx_cnt <= tx_cnt + tirq[0];
   end
   suw_uart #(.N_CH(3), .BAUD_DIV(1)) suw_uart_inst (
      .clk(clk), .rst(rst), .cfg(cfg), .wakeup_set(wset), .error_clear(eclr),
      .rx_read(rrd), .tx_valid(tval), .tx_data(tdat), .tx_ready(trdy), .stat(stat),
      .wakeup_filter_enable(wake), .receive_irq(rirq), .transmit_irq(tirq),
      .serial_in_pin({2'h3, pin}), .serial_out_o(so), .serial_out_oe(soe),
      .shift_clock_i({2'h3, xclk}), .shift_clock_o(sclk), .shift_clock_oe(scoe));
   suw_peer suw_peer_inst (.clk(clk), .line(pin));
   task automatic results();
      $display("compares %0d, mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : results
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Start, body bits, high stop
   function automatic logic [11:0] frame(input logic [9:0] b, input int nb);
      return (12'h1 << (nb + 1)) | {1'h0, b, 1'h0};
   endfunction : frame
   // Bits: parity on, even, ninth, receive on, open drain; code fixed
   task automatic setc(input logic [1:0] m, input logic [4:0] b);
      @(posedge clk);
      cfg[0] <= {m, b[4:1], 2'h0, b[0], 8'h0a};
   endtask : setc
   // One-cycle strobes: filter set, flag clear, read
   task automatic pulse(input logic [2:0] s);
      @(posedge clk);
      {wset[0], eclr[0], rrd[0]} <= s;
      @(posedge clk);
      {wset[0], eclr[0], rrd[0]} <= 3'h0;
      @(negedge clk);
   endtask : pulse
   // Sends a byte and samples each line bit at its middle
   task automatic send(input logic [7:0] d, input logic [11:0] f, input int n);
      logic [11:0] seen;
      int          t0;
      seen = '0;
      t0 = tx_cnt;
      @(posedge clk);
      tdat[0] <= d;
      tval[0] <= 1'h1;
      @(negedge clk);
      for (int i = 0; i < 400 && trdy[0] !== 1'h1; i++) @(negedge clk);
      check(trdy[0], 1'h1);
      if (trdy[0] !== 1'h1) results();
      @(posedge clk);
      tval[0] <= 1'h0;
      repeat (8) @(negedge clk);
      for (int i = 0; i < n; i++) begin
         seen[i] = line;
         repeat (16) @(negedge clk);
      end
      check(seen, f);
      check(tx_cnt - t0, 1);
   endtask : send
   // Peer sends a frame; a negative count skips the event check
   task automatic recv(input logic [11:0] f, input int n, input int irqs);
      int r0;
      r0 = rx_cnt;
      suw_peer_inst.drive(f, n);
      repeat (6) @(negedge clk);
      if (irqs >= 0) check(rx_cnt - r0, irqs);
   endtask : recv
   task automatic t_tx();
      for (int p = 0; p < 2; p++) begin
         setc(suw_pkg::MODE_8BIT, {1'h1, p[0], 3'h0});
         send(8'h5b, frame({p[0], 8'h5b}, 9), 11);
      end
      setc(suw_pkg::MODE_7BIT, 5'h0);
      send(8'hc5, frame(10'h45, 7), 9);
      setc(suw_pkg::MODE_9BIT, 5'h1d);
      send(8'h3c, frame({1'h1, 8'h3c}, 9), 11);
      $display("t_tx done");
   endtask : t_tx
   task automatic t_rx();
      setc(suw_pkg::MODE_7BIT, 5'h0);
      recv(frame(10'h2b, 7), 9, 0);
      setc(suw_pkg::MODE_7BIT, 5'h02);
      recv(frame(10'h2b, 7), 9, 1);
      check(stat[0], {8'h2b, 5'h01});
      recv(frame(10'h11, 7), 9, -1);
      check(stat[0], {8'h2b, 5'h09});
      pulse(3'h3);
      setc(suw_pkg::MODE_8BIT, 5'h1a);
      recv(frame({1'h1, 8'h81}, 9) & 12'h3ff, 11, 1);
      check(stat[0], {8'h81, 5'h07});
      pulse(3'h3);
      check(stat[0][3:0], 4'h0);
      $display("t_rx done");
   endtask : t_rx
   task automatic t_wake();
      setc(suw_pkg::MODE_9BIT, 5'h12);
      pulse(3'h7);
      recv(frame({1'h0, 8'h0a}, 9), 11, 0);
      recv(frame({1'h1, 8'h33}, 9), 11, 1);
      check({stat[0], wake[0]}, {8'h33, 5'h11, 1'h1});
      pulse(3'h1);
      recv(frame({1'h1, 8'h0a}, 9), 11, 1);
      check(wake[0], 1'h0);
      pulse(3'h1);
      recv(frame({1'h0, 8'h77}, 9), 11, 1);
      check(stat[0], {8'h77, 5'h01});
      $display("t_wake done");
   endtask : t_wake
   // Shift mode: internal clock, then external clock rising and falling
   task automatic t_shift();
      logic [7:0] got;
      logic       prev, ln;
      int         t0, r0;
      for (int k = 0; k < 3; k++) begin
         pulse(3'h3);
         got = '0;
         prev = 1'h1;
         ln = 1'h1;
         t0 = tx_cnt;
         r0 = rx_cnt;
         @(posedge clk);
         cfg[0] <= {suw_pkg::MODE_SHIFT, 4'h1, k != 0, k == 2, 1'h0, 8'h0a};
         tdat[0] <= 8'ha6;
         tval[0] <= 1'h1;
         @(posedge clk);
         tval[0] <= 1'h0;
         // Internal clock: take the bit held just before each rise
         for (int i = 0; i < 160 && k == 0; i++) begin
            @(negedge clk);
            if (sclk[0] && !prev) got = {ln, got[7:1]};
            prev = sclk[0];
            ln = line;
         end
         // External clock: sample before each active edge, then toggle
         for (int i = 0; i < 16 && k != 0; i++) begin
            repeat (4) @(negedge clk);
            if (xclk == (k == 2)) got = {line, got[7:1]};
            @(posedge clk);
            xclk <= ~xclk;
         end
         repeat (4) @(negedge clk);
         check(got, 8'ha6);
         check(tx_cnt - t0, 1);
         check(rx_cnt - r0, 1);
         check(stat[0], {8'hff, 5'h01});
         check({sclk[0], scoe[0]}, {1'h1, k == 0});
         setc(suw_pkg::MODE_8BIT, 5'h0);
      end
      $display("t_shift done");
   endtask : t_shift
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'h0;
      t_tx();
      t_rx();
      t_wake();
      t_shift();
      results();
   end
endmodule : test_suw_uart
